// >>> include/ioh_cfg.svh
// constants for the io status and command handler
`ifndef IOH_CFG_SVH
`define IOH_CFG_SVH
`define IOH_CLK_HZ 125000000
`define IOH_TICK_MS 500
`define IOH_TICK_CYC ((`IOH_CLK_HZ / 1000) * `IOH_TICK_MS)
`define IOH_PERIOD_MAX 3600
`define IOH_MAX_ADJ 10
`define IOH_ST_VALID 3'h0
`define IOH_ST_PEND 3'h1
`define IOH_ST_HIGH 3'h2
`define IOH_ST_LOW 3'h3
`define IOH_ST_ERR 3'h4
`define IOH_MODE_MANUAL 3'h0
`define IOH_MODE_TON 3'h1
`define IOH_MODE_TOFF 3'h2
`define IOH_CNT_OFF 2'h0
`define IOH_CNT_RISE 2'h1
`define IOH_CNT_FALL 2'h2
`define IOH_CNT_BOTH 2'h3
`define IOH_UNIT_C 8'h43
`define IOH_UNIT_F 8'h46
`define IOH_UNIT_K 8'h4B
`define IOH_CH_0 8'h30
`define IOH_CH_1 8'h31
`endif

// >>> include/ioh_pkg.sv
// types for the io status and command handler
package ioh_pkg;
    typedef enum logic [7:0] {
        IOH_CMD_NONE = 8'h00,
        IOH_CMD_ON = 8'h01,
        IOH_CMD_OFF = 8'h02,
        IOH_CMD_INV = 8'h04,
        IOH_CMD_PULSE = 8'h08,
        IOH_CMD_SUB = 8'h10,
        IOH_CMD_CLR = 8'h20,
        IOH_CMD_ALL_ON = 8'h40,
        IOH_CMD_BULK = 8'h80
    } ioh_cmd_t;
    typedef struct packed {
        ioh_cmd_t op;
        logic [7:0] idx;
        logic [7:0] dur;
        logic [15:0] amount;
        logic auth_ok;
    } ioh_req_t;
    typedef enum logic [1:0] {
        IOH_TS_IDLE = 2'b01,
        IOH_TS_HOLD = 2'b10
    } ioh_tstate_t;
endpackage

// >>> rtl/ioh_handler.sv
// io status reporting and command execution core
// Summary of operation
// - input state code: 0 valid, 1 pending, 4 detection failure.
// - output state code: 0 valid, 1 pending, 4 detection failure.
// - output mode: 0 manual, 1 timed on, 2 timed off, 3-6 temperature.
// - thermometer state: 0 valid, 1 before first reading, 4 sensor error.
// - unit reported as ASCII C, F or K.
// - periodic report every configured seconds, at most 3600.
// - report at once when a monitored point changes.
// - report carries one 0/1 character per input and per output.
// - temperature state 0 valid,1 pending,2 high,3 low,4 error.
// - report carries one counter per input, indices from one.
// - bulk 0 switches off, 1 on, only in manual mode.
// - X leaves output unchanged; partner uses X under temperature control.
// - counter parameter subtracts, partner never exceeds current count.
// - at most ten counter adjusts per instruction, rest ignored.
// - switch on closes output, optional 1-255 half-second hold.
// - switch off opens output, optional 1-255 half-second hold.
// - invert toggles the indexed output.
// - pulse starts the preconfigured pulse on the indexed output.
// - single adjust subtracts amount from indexed counter.
// - reset-all clears every counter at once.
// - all-on switches every output on together.
// - commands without valid credentials are rejected when credentials set.
// - all-output commands act only if every output is manual.
// - counter mode 0 off, 1 rising, 2 falling, 3 both.
// - counters hold up to 65535.
`timescale 1ns/1ps
`include "ioh_cfg.svh"
module ioh_handler #(
    parameter int N_IN = 8,
    parameter int N_OUT = 8,
    parameter int TICK_CYC = `IOH_TICK_CYC
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic [N_IN-1:0] in_val, // input levels
    input wire logic [N_IN-1:0] in_fail, // input detection failure
    input wire logic [N_OUT-1:0] out_fail, // output detection failure
    input wire logic [2*N_IN-1:0] cnt_mode, // per-input counter modes
    input wire logic [3*N_OUT-1:0] out_mode, // per-output modes
    input wire logic [8*N_OUT-1:0] pulse_len, // preconfigured pulse lengths
    input wire logic [N_IN-1:0] in_mon_en, // input change monitoring
    input wire logic [N_OUT-1:0] out_mon_en, // output change monitoring
    input wire logic per_en, // periodic reporting enable
    input wire logic [11:0] per_sec, // report interval in seconds
    input wire logic cred_set, // credentials configured
    input wire logic [1:0] unit_sel, // 0 C, 1 F, 2 K
    input wire logic temp_done, // first measurement complete
    input wire logic temp_err, // sensor error
    input wire logic signed [15:0] temp_reading, // measured temperature
    input wire logic signed [15:0] low_temp_limit, // lower limit
    input wire logic signed [15:0] high_temp_limit, // upper limit
    input wire ioh_pkg::ioh_req_t req, // command request
    input wire logic req_valid, // request strobe
    input wire logic [2*N_OUT-1:0] bulk_codes, // bulk codes: 0 off,1 on,2 keep
    input wire logic adj_start, // start of counter-adjust instruction
    output logic req_done, // command executed pulse
    output logic req_rej, // command rejected pulse
    output logic [N_OUT-1:0] out_state, // output drive, 1 closed
    output logic [8*N_IN-1:0] ins_chars, // report input characters
    output logic [8*N_OUT-1:0] outs_chars, // report output characters
    output logic [3*N_IN-1:0] in_sts, // input state codes
    output logic [3*N_OUT-1:0] out_sts, // output state codes
    output logic [2:0] therm_sts, // thermometer state code
    output logic [2:0] temp_sts, // reported temperature state
    output logic [7:0] unit_char, // unit letter
    output logic [16*N_IN-1:0] cnt_vals, // counters, input 1 lowest
    output logic report // report request pulse
);
    import ioh_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // time base
    logic [$clog2(TICK_CYC+1)-1:0] div_reg;
    logic half_tick;
    logic sec_phase_reg;
    logic [11:0] sec_cnt_reg;
    assign half_tick = (div_reg == ($clog2(TICK_CYC+1))'(TICK_CYC - 1));
    always_ff @(posedge clk) begin
        if (sys_rst || half_tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // status codes
    logic [N_IN-1:0] in_seen_reg;
    logic [N_IN-1:0] in_prev_reg;
    logic [N_OUT-1:0] out_prev_reg;
    logic out_seen_reg;
    assign therm_sts = temp_err ? `IOH_ST_ERR : (temp_done ? `IOH_ST_VALID : `IOH_ST_PEND);
    wire temp_hi = temp_reading > high_temp_limit;
    wire temp_lo = temp_reading < low_temp_limit;
    assign temp_sts = temp_err ? `IOH_ST_ERR : !temp_done ? `IOH_ST_PEND :
                      temp_hi ? `IOH_ST_HIGH : temp_lo ? `IOH_ST_LOW : `IOH_ST_VALID;
    assign unit_char = (unit_sel == 2'h1) ? `IOH_UNIT_F : (unit_sel == 2'h2) ? `IOH_UNIT_K : `IOH_UNIT_C;
    ////////////////////////////////////////////////////////////////////////////
    // authorisation and decoding
    wire auth = !cred_set || req.auth_ok;
    wire go = req_valid && auth;
    logic all_manual;
    always_comb begin
        all_manual = 1'b1;
        for (int k = 0; k < N_OUT; k++) begin
            if (out_mode[3*k +: 3] != `IOH_MODE_MANUAL) begin
                all_manual = 1'b0;
            end
        end
    end
    wire all_ok = all_manual;
    wire is_all = (req.op == IOH_CMD_ALL_ON) || (req.op == IOH_CMD_BULK);
    wire blocked = is_all && !all_ok;
    wire [7:0] id0 = req.idx - 8'h01;
    logic [3:0] adj_cnt_reg;
    wire adj_room = adj_start || (adj_cnt_reg < 4'(`IOH_MAX_ADJ));
    wire sub_ok = (req.op != IOH_CMD_SUB) || adj_room;
    wire exec = go && !blocked && sub_ok;
    wire sub_take = go && req.op == IOH_CMD_SUB;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adj_cnt_reg <= '0;
        end else if (adj_start) begin
            adj_cnt_reg <= {3'h0, sub_take}; // an adjust in the opening cycle is the first of the new instruction
        end else if (sub_take && adj_room) begin
            adj_cnt_reg <= adj_cnt_reg + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_done <= 1'b0;
            req_rej <= 1'b0;
        end else begin
            req_done <= exec;
            req_rej <= req_valid && !exec;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // per-input counters
    logic [N_IN-1:0] in_chg;
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            logic [15:0] cnt_reg;
            logic [15:0] cnt_next;
            logic [15:0] sub_amt;
            wire rise = in_val[gi] && !in_prev_reg[gi];
            wire fall = !in_val[gi] && in_prev_reg[gi];
            wire [1:0] md = cnt_mode[2*gi +: 2];
            wire hit = (md == `IOH_CNT_RISE && rise) || (md == `IOH_CNT_FALL && fall) ||
                       (md == `IOH_CNT_BOTH && (rise || fall));
            wire sel = exec && req.op == IOH_CMD_SUB && id0 == 8'(gi);
            assign sub_amt = sel ? req.amount : 16'h0000;
            always_comb begin
                cnt_next = cnt_reg - sub_amt;
                if (hit && cnt_next != 16'hFFFF) begin
                    cnt_next = cnt_next + 16'h0001;
                end
                if (exec && req.op == IOH_CMD_CLR) begin
                    cnt_next = 16'h0000;
                end
            end
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    cnt_reg <= 16'h0000;
                end else begin
                    cnt_reg <= cnt_next;
                end
            end
            assign cnt_vals[16*gi +: 16] = cnt_reg;
            assign ins_chars[8*gi +: 8] = in_val[gi] ? `IOH_CH_1 : `IOH_CH_0;
            assign in_sts[3*gi +: 3] = in_fail[gi] ? `IOH_ST_ERR :
                                       (in_seen_reg[gi] ? `IOH_ST_VALID : `IOH_ST_PEND);
            assign in_chg[gi] = in_mon_en[gi] && (rise || fall);
            AST_CNT_NO_WRAP: assert property (@(posedge clk) disable iff (sys_rst)
                (hit && !sel && !(exec && req.op == IOH_CMD_CLR)) |=> (cnt_reg != 16'h0000))
                else $error("counter wrapped on a counted edge");
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_prev_reg <= in_val; // pin level taken in reset, so no false edge after release
            in_seen_reg <= '0;
            out_seen_reg <= 1'b0;
            out_prev_reg <= '0;
        end else begin
            in_prev_reg <= in_val;
            in_seen_reg <= '1;
            out_seen_reg <= 1'b1;
            out_prev_reg <= out_state;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // outputs with timed holds
    genvar go_i;
    generate
        for (go_i = 0; go_i < N_OUT; go_i++) begin : g_out
            ioh_tstate_t ts_reg;
            logic [7:0] tm_reg;
            logic st_reg;
            wire [2:0] md = out_mode[3*go_i +: 3];
            wire manual = (md == `IOH_MODE_MANUAL);
            wire me = exec && id0 == 8'(go_i);
            wire [1:0] bc = bulk_codes[2*go_i +: 2];
            wire expire = (ts_reg == IOH_TS_HOLD) && half_tick && tm_reg == 8'h01;
            wire pls_on = (md == `IOH_MODE_TOFF) ? 1'b0 : 1'b1;
            wire pls_go = me && req.op == IOH_CMD_PULSE && pulse_len[8*go_i +: 8] != 8'h00;
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    st_reg <= 1'b0;
                    tm_reg <= 8'h00;
                    ts_reg <= IOH_TS_IDLE;
                end else if (me && (req.op == IOH_CMD_ON || req.op == IOH_CMD_OFF)) begin
                    st_reg <= (req.op == IOH_CMD_ON);
                    tm_reg <= req.dur;
                    ts_reg <= (req.dur != 8'h00) ? IOH_TS_HOLD : IOH_TS_IDLE;
                end else if (pls_go) begin
                    st_reg <= pls_on;
                    tm_reg <= pulse_len[8*go_i +: 8];
                    ts_reg <= IOH_TS_HOLD;
                end else if (me && req.op == IOH_CMD_INV) begin
                    st_reg <= !st_reg;
                    ts_reg <= IOH_TS_IDLE;
                end else if (exec && req.op == IOH_CMD_ALL_ON) begin
                    st_reg <= 1'b1;
                    ts_reg <= IOH_TS_IDLE;
                end else if (exec && req.op == IOH_CMD_BULK && manual && bc != 2'h2) begin
                    st_reg <= bc[0];
                    ts_reg <= IOH_TS_IDLE;
                end else begin
                    case (ts_reg)
                        IOH_TS_IDLE: begin
                            tm_reg <= 8'h00;
                        end
                        IOH_TS_HOLD: begin
                            if (expire) begin
                                st_reg <= !st_reg;
                                tm_reg <= 8'h00;
                                ts_reg <= IOH_TS_IDLE;
                            end else if (half_tick) begin
                                tm_reg <= tm_reg - 8'h01;
                            end
                        end
                        default: begin
                            ts_reg <= IOH_TS_IDLE;
                        end
                    endcase
                end
            end
            assign out_state[go_i] = st_reg;
            assign outs_chars[8*go_i +: 8] = st_reg ? `IOH_CH_1 : `IOH_CH_0;
            assign out_sts[3*go_i +: 3] = out_fail[go_i] ? `IOH_ST_ERR :
                                          (out_seen_reg ? `IOH_ST_VALID : `IOH_ST_PEND);
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////////
    // report scheduling
    wire out_chg = |(out_mon_en & (out_state ^ out_prev_reg));
    wire [11:0] per_lim = (per_sec > 12'(`IOH_PERIOD_MAX)) ? 12'(`IOH_PERIOD_MAX) : per_sec;
    wire sec_tick = half_tick && sec_phase_reg;
    wire per_fire = per_en && sec_tick && per_lim != 12'h000 && (sec_cnt_reg + 12'h001 >= per_lim);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sec_phase_reg <= 1'b0;
            sec_cnt_reg <= 12'h000;
            report <= 1'b0;
        end else begin
            if (half_tick) begin
                sec_phase_reg <= !sec_phase_reg;
            end
            if (!per_en || per_fire) begin
                sec_cnt_reg <= 12'h000;
            end else if (sec_tick) begin
                sec_cnt_reg <= sec_cnt_reg + 12'h001;
            end
            report <= per_fire || (|in_chg) || out_chg;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_REJ_NOAUTH: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && cred_set && !req.auth_ok) |=> (req_rej && !req_done))
        else $error("unauthorised command not rejected");
    AST_CLR_ALL: assert property (@(posedge clk) disable iff (sys_rst)
        (exec && req.op == IOH_CMD_CLR && in_val == in_prev_reg) |=> (cnt_vals == '0))
        else $error("counters not cleared");
    AST_ALL_ON: assert property (@(posedge clk) disable iff (sys_rst)
        (go && req.op == IOH_CMD_ALL_ON && all_manual) |=> (out_state == '1))
        else $error("all-on failed");
    AST_ALL_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && is_all && !all_manual) |=> req_rej)
        else $error("all-output command not blocked");
    AST_ADJ_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
        (adj_cnt_reg == 4'(`IOH_MAX_ADJ) && !adj_start && req_valid && req.op == IOH_CMD_SUB) |=> req_rej)
        else $error("eleventh adjust processed");
    AST_REPORT_CHG: assert property (@(posedge clk) disable iff (sys_rst)
        (|in_chg) |=> report)
        else $error("change not reported");
    AST_TEMP_HI: assert property (@(posedge clk) disable iff (sys_rst)
        (!temp_err && temp_done && temp_reading > high_temp_limit) |-> (temp_sts == `IOH_ST_HIGH))
        else $error("high temperature state wrong");
    AST_ON_CMD: assert property (@(posedge clk) disable iff (sys_rst)
        (exec && req.op == IOH_CMD_ON && req.idx == 8'h01) |=> out_state[0])
        else $error("switch-on failed");
    AST_OFF_CMD: assert property (@(posedge clk) disable iff (sys_rst)
        (exec && req.op == IOH_CMD_OFF && req.idx == 8'h01) |=> !out_state[0])
        else $error("switch-off failed");
endmodule // ioh_handler

// >>> test/ioh_partner.sv
// far-side model that issues commands and bulk strings to the handler
`timescale 1ns/1ps
module ioh_partner #(
    parameter int N_OUT = 4
) (
    input wire logic clk, // system clock
    input wire logic req_done, // executed pulse
    input wire logic req_rej, // rejected pulse
    output ioh_pkg::ioh_req_t req, // command request
    output logic req_valid, // request strobe
    output logic [2*N_OUT-1:0] bulk_codes, // bulk codes per output
    output logic adj_start // start of a new adjust instruction
);
    import ioh_pkg::*;
    initial begin
        req = '0;
        req_valid = 1'b0;
        bulk_codes = '0;
        adj_start = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one character per output, the leftmost one is output 1
    task automatic load_bulk(input string s);
        for (int k = 0; k < N_OUT; k++) begin
            case (s[k])
                8'h30: bulk_codes[2*k +: 2] = 2'h0;
                8'h31: bulk_codes[2*k +: 2] = 2'h1;
                default: bulk_codes[2*k +: 2] = 2'h2; // keep, used for temperature outputs
            endcase
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // request held through the taking edge, answer read in the next cycle
    task automatic issue(input ioh_cmd_t op, input logic [7:0] idx, input logic [7:0] dur,
                         input logic [15:0] amount, input logic auth, output logic done, output logic rej);
        @(negedge clk);
        req = '{op: op, idx: idx, dur: dur, amount: amount, auth_ok: auth};
        req_valid = 1'b1;
        @(negedge clk);
        done = req_done;
        rej = req_rej;
        req_valid = 1'b0;
        req = ioh_req_t'(~req);
    endtask
    task automatic new_instr();
        @(negedge clk);
        adj_start = 1'b1;
        @(negedge clk);
        adj_start = 1'b0;
    endtask
endmodule // ioh_partner

// >>> test/tb.sv
// self-checking bench for the io status and command handler
`timescale 1ns/1ps
module tb;
    import ioh_pkg::*;
    localparam int NI = 2;
    localparam int NO = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [NI-1:0] in_val = '0, in_fail = '0, in_mon_en = '0;
    logic [NO-1:0] out_fail = '0, out_mon_en = '0, out_state;
    logic [2*NI-1:0] cnt_mode = '0;
    logic [3*NO-1:0] out_mode = '0, out_sts;
    logic [8*NO-1:0] pulse_len = 32'h0000_0200, outs_chars;
    logic per_en = 1'b0, cred_set = 1'b0, temp_done = 1'b0, temp_err = 1'b0, req_valid, adj_start;
    logic req_done, req_rej, report;
    logic [11:0] per_sec = 12'h001;
    logic [1:0] unit_sel = 2'h0;
    logic signed [15:0] temp_reading = 16'h0014, low_temp_limit = 16'hFFF6, high_temp_limit = 16'h001E;
    ioh_req_t req;
    logic [2*NO-1:0] bulk_codes;
    logic [8*NI-1:0] ins_chars;
    logic [3*NI-1:0] in_sts;
    logic [2:0] therm_sts, temp_sts;
    logic [7:0] unit_char;
    logic [16*NI-1:0] cnt_vals;
    int err_total = 0, cmp_count = 0, rpt_cnt = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (report === 1'b1) rpt_cnt++;
    ioh_handler #(.N_IN(NI), .N_OUT(NO), .TICK_CYC(10)) ioh_handler_i (.clk(clk), .sys_rst(sys_rst),
        .in_val(in_val), .in_fail(in_fail), .out_fail(out_fail), .cnt_mode(cnt_mode), .out_mode(out_mode),
        .pulse_len(pulse_len), .in_mon_en(in_mon_en), .out_mon_en(out_mon_en), .per_en(per_en),
        .per_sec(per_sec), .cred_set(cred_set), .unit_sel(unit_sel), .temp_done(temp_done),
        .temp_err(temp_err), .temp_reading(temp_reading), .low_temp_limit(low_temp_limit),
        .high_temp_limit(high_temp_limit), .req(req), .req_valid(req_valid), .bulk_codes(bulk_codes),
        .adj_start(adj_start), .req_done(req_done), .req_rej(req_rej), .out_state(out_state),
        .ins_chars(ins_chars), .outs_chars(outs_chars), .in_sts(in_sts), .out_sts(out_sts),
        .therm_sts(therm_sts), .temp_sts(temp_sts), .unit_char(unit_char), .cnt_vals(cnt_vals), .report(report));
    ioh_partner #(.N_OUT(NO)) ioh_partner_i (.clk(clk), .req_done(req_done), .req_rej(req_rej), .req(req),
        .req_valid(req_valid), .bulk_codes(bulk_codes), .adj_start(adj_start));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic cmd(input ioh_cmd_t op, input int idx, input int dur, input int amt, input logic auth,
                       input logic ok);
        logic d;
        logic r;
        ioh_partner_i.issue(op, 8'(idx), 8'(dur), 16'(amt), auth, d, r);
        check("req_done", d, ok);
        check("req_rej", r, !ok);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic set_temp(input logic dn, input logic er, input int rd, input int th, input int ts);
        temp_done = dn;
        temp_err = er;
        temp_reading = 16'(rd);
        @(negedge clk);
        check("therm_sts", therm_sts, th);
        check("temp_sts", temp_sts, ts);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_codes();
        for (int u = 0; u < 3; u++) begin
            unit_sel = 2'(u);
            @(negedge clk);
            check("unit_char", unit_char, u == 0 ? 8'h43 : (u == 1 ? 8'h46 : 8'h4B));
        end
        set_temp(1'b0, 1'b0, 20, 1, 1);
        set_temp(1'b1, 1'b1, 20, 4, 4);
        set_temp(1'b1, 1'b0, 20, 0, 0);
        set_temp(1'b1, 1'b0, 40, 0, 2);
        set_temp(1'b1, 1'b0, -20, 0, 3);
        in_fail = 2'b10;
        out_fail = 4'b0001;
        in_val = 2'b01;
        @(negedge clk);
        check("in_sts", in_sts, 6'o40);
        check("out_sts", out_sts, 12'o0004);
        check("ins_chars", ins_chars, 16'h3031);
        in_fail = '0;
        out_fail = '0;
        in_val = '0;
        $display("test codes done");
    endtask
    task automatic t_outputs();
        cmd(IOH_CMD_ON, 1, 0, 0, 1, 1);
        check("outs_chars", outs_chars, 32'h3030_3031);
        cmd(IOH_CMD_OFF, 1, 0, 0, 1, 1);
        check("out_state", out_state, 4'b0000);
        cmd(IOH_CMD_ON, 2, 2, 0, 1, 1);
        wait_cyc(8);
        check("out_state", out_state, 4'b0010);
        wait_cyc(25);
        check("out_state", out_state, 4'b0000);
        cmd(IOH_CMD_ON, 3, 0, 0, 1, 1);
        cmd(IOH_CMD_OFF, 3, 2, 0, 1, 1);
        check("out_state", out_state, 4'b0000);
        wait_cyc(33);
        check("out_state", out_state, 4'b0100);
        cmd(IOH_CMD_INV, 1, 0, 0, 1, 1);
        cmd(IOH_CMD_INV, 3, 0, 0, 1, 1);
        check("out_state", out_state, 4'b0001);
        cmd(IOH_CMD_PULSE, 2, 0, 0, 1, 1);
        check("out_state", out_state, 4'b0011);
        wait_cyc(33);
        check("out_state", out_state, 4'b0001);
        out_mode = 12'o0020;
        cmd(IOH_CMD_PULSE, 2, 0, 0, 1, 1);
        check("out_state", out_state, 4'b0001);
        wait_cyc(33);
        check("out_state", out_state, 4'b0011);
        out_mode = '0;
        $display("test outputs done");
    endtask
    task automatic t_all();
        cmd(IOH_CMD_ALL_ON, 0, 0, 0, 1, 1);
        check("out_state", out_state, 4'b1111);
        ioh_partner_i.load_bulk("01X0");
        cmd(IOH_CMD_BULK, 0, 0, 0, 1, 1);
        check("out_state", out_state, 4'b0110);
        out_mode = 12'o3000;
        cmd(IOH_CMD_ALL_ON, 0, 0, 0, 1, 0);
        check("out_state", out_state, 4'b0110);
        out_mode = '0;
        cred_set = 1'b1;
        cmd(IOH_CMD_INV, 1, 0, 0, 0, 0);
        check("out_state", out_state, 4'b0110);
        cmd(IOH_CMD_INV, 1, 0, 0, 1, 1);
        check("out_state", out_state, 4'b0111);
        cred_set = 1'b0;
        $display("test all outputs done");
    endtask
    task automatic t_counters();
        int e;
        for (int m = 0; m < 4; m++) begin
            cnt_mode = {2'(m), 2'(m)};
            cmd(IOH_CMD_CLR, 0, 0, 0, 1, 1);
            in_val = 2'b11;
            wait_cyc(3);
            in_val = 2'b00;
            wait_cyc(3);
            e = (m == 0) ? 0 : ((m == 3) ? 2 : 1);
            check("cnt_vals", cnt_vals, {16'(e), 16'(e)});
        end
        ioh_partner_i.new_instr();
        cmd(IOH_CMD_SUB, 2, 0, 1, 1, 1); // amount within current count
        check("cnt_vals", cnt_vals, {16'h0001, 16'h0002});
        for (int k = 0; k < 9; k++) cmd(IOH_CMD_SUB, 1, 0, 0, 1, 1);
        cmd(IOH_CMD_SUB, 1, 0, 1, 1, 0);
        ioh_partner_i.new_instr();
        cmd(IOH_CMD_SUB, 1, 0, 2, 1, 1);
        check("cnt_vals", cnt_vals, {16'h0001, 16'h0000});
        cmd(IOH_CMD_CLR, 0, 0, 0, 1, 1);
        check("cnt_vals", cnt_vals, 32'h0);
        $display("test counters done");
    endtask
    task automatic t_report();
        in_mon_en = 2'b01;
        out_mon_en = 4'b0001;
        wait_cyc(3);
        rpt_cnt = 0;
        in_val = 2'b10;
        wait_cyc(4);
        check("report quiet", rpt_cnt, 0);
        in_val = 2'b11;
        wait_cyc(4);
        check("report input", rpt_cnt, 1);
        cmd(IOH_CMD_INV, 1, 0, 0, 1, 1);
        wait_cyc(3);
        check("report output", rpt_cnt, 2);
        in_mon_en = '0;
        out_mon_en = '0;
        for (int s = 1; s < 3; s++) begin
            per_sec = 12'(s);
            per_en = 1'b1;
            rpt_cnt = 0;
            wait_cyc(100 * s);
            check("periodic", rpt_cnt >= 4 && rpt_cnt <= 6, 1);
            per_en = 1'b0;
        end
        $display("test report done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 8);
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        check("in_sts reset", in_sts, 6'o11);
        check("out_state reset", out_state, 4'b0000);
        check("out_sts reset", out_sts, 12'o1111);
        sys_rst = 1'b0;
        wait_cyc(2);
        t_codes();
        t_outputs();
        t_all();
        t_counters();
        t_report();
        report_and_stop();
    end
endmodule // tb
